// >>> hw/fts_pkg.sv
package fts_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 21;
  localparam int DATA_W = 48;
  localparam int LANES = 6;
  localparam int LANE_W = 8;
  localparam int BURST_W = 2;
  localparam int BASE_W = ADDR_W - BURST_W;
  localparam int INIT_CNT_W = 16;

  // ----------------------------------------
  // pin levels
  // ----------------------------------------
  localparam logic SEL_A_ON = 1'b0;
  localparam logic SEL_B_ON = 1'b1;
  localparam logic SEL_C_ON = 1'b0;
  localparam logic WRITE_ON = 1'b0;
  localparam logic GATE_ON = 1'b0;
  localparam logic LOAD_LEVEL = 1'b0;
  localparam logic OE_ON = 1'b0;
  localparam logic MASK_ON = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;

  // ----------------------------------------
  // reset values and counts
  // ----------------------------------------
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [BASE_W-1:0] BASE_ZERO = 19'h0;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 21'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 48'h0;
  localparam logic [LANES-1:0] LANES_OFF = 6'h0;
  localparam logic [INIT_CNT_W-1:0] INIT_ZERO = 16'h0;
  localparam logic [INIT_CNT_W-1:0] INIT_ONE = 16'h1;

  // ----------------------------------------
  // types
  // ----------------------------------------
  // kind of access held between edges
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } fts_op_type;

  // ready pin sequence
  typedef enum logic [1:0] {
    RDY_INIT,
    RDY_PULSE,
    RDY_DONE
  } fts_rdy_type;

  // one sampled bus command
  typedef struct packed {
    logic gate;
    logic selected;
    logic write;
    logic load;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_en;
  } fts_cmd_type;

  // one write to the array
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_en;
    logic [DATA_W-1:0] data;
  } fts_wr_type;

endpackage

// >>> hw/fts_mem.sv
`timescale 1ns/1ps
`default_nettype none
module fts_mem
  import fts_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire fts_wr_type wr,
  output logic [DATA_W-1:0] rd_data
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1]; // word array
  logic [DATA_W-1:0] old_wr; // word under write
  logic [DATA_W-1:0] old_rd; // word under read
  logic [DATA_W-1:0] new_wr; // merged write word
  logic [DATA_W-1:0] new_rd; // forwarded read word
  logic [DATA_W-1:0] rd_data_q; // read register
  logic [DATA_W-1:0] rd_data_d;
  logic same_addr; // read hits the word being written

  assign old_wr = mem[wr.addr];
  assign old_rd = mem[rd_addr];
  assign same_addr = wr.en && (wr.addr == rd_addr);

  // ----------------------------------------
  // per-lane merge
  // ----------------------------------------
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign new_wr[i*LANE_W +: LANE_W] = wr.lane_en[i] ?
      wr.data[i*LANE_W +: LANE_W] : old_wr[i*LANE_W +: LANE_W];
    // forward a same-edge write to the read
    assign new_rd[i*LANE_W +: LANE_W] = (same_addr && wr.lane_en[i]) ?
      wr.data[i*LANE_W +: LANE_W] : old_rd[i*LANE_W +: LANE_W];
  end

  // array write, no reset on contents
  always_ff @(posedge clk) begin
    if (wr.en) begin
      mem[wr.addr] <= new_wr;
    end
  end

  // read register next value, holds when not read
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_en) begin
      rd_data_d = new_rd;
    end
  end

  // read register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= DATA_ZERO;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;

endmodule
`default_nettype wire

// >>> hw/fts_port.sv
`timescale 1ns/1ps
`default_nettype none
module fts_port
  import fts_pkg::*;
#(
  parameter logic [INIT_CNT_W-1:0] INIT_CYCLES = 16'h0010
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic SELECT_LOW_A_N,
  input wire logic SELECT_HIGH_B,
  input wire logic SELECT_LOW_C_N,
  input wire logic WE_N,
  input wire logic [LANES-1:0] BYTE_WRITE_MASK_N,
  input wire logic BURST_STEP_OR_LOAD,
  input wire logic CLOCK_GATE_N,
  input wire logic OE_N,
  input wire logic BURST_ORDER,
  input wire logic [DATA_W-1:0] DQ_I,
  output logic [DATA_W-1:0] DQ_O,
  output logic DQ_OE,
  output logic READY_O,
  output logic READY_OE
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_q; // first reset stage
  logic rst_n; // released reset copy

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ----------------------------------------
  // asynchronous pin synchronisers
  // ----------------------------------------
  logic oe_s1_q; // output enable stage one
  logic oe_s2_q; // output enable stage two
  logic ord_s1_q; // order strap stage one
  logic ord_s2_q; // order strap stage two

  // two flops each, first stage read only by second
  // no reset: the strap is already settled when the latch opens
  always_ff @(posedge CLK) begin
    oe_s1_q <= OE_N;
    oe_s2_q <= oe_s1_q;
    ord_s1_q <= BURST_ORDER;
    ord_s2_q <= ord_s1_q;
  end

  // ----------------------------------------
  // burst order strap
  // ----------------------------------------
  logic strap_done_q; // order latched
  logic strap_done_d;
  logic interleave_q; // interleaved order chosen
  logic interleave_d;

  always_comb begin
    strap_done_d = strap_done_q;
    interleave_d = interleave_q;
    if (!strap_done_q) begin
      strap_done_d = 1'b1;
      interleave_d = (ord_s2_q == ORDER_INTERLEAVED);
    end
  end

  // strap register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      interleave_q <= 1'b0;
    end else begin
      strap_done_q <= strap_done_d;
      interleave_q <= interleave_d;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  fts_cmd_type cmd; // sampled pins as one bundle

  // edge counts only with gate low
  assign cmd.gate = (CLOCK_GATE_N == GATE_ON);
  assign cmd.selected = (SELECT_LOW_A_N == SEL_A_ON) &&
    (SELECT_HIGH_B == SEL_B_ON) && (SELECT_LOW_C_N == SEL_C_ON);
  // write enable low starts a write
  assign cmd.write = (WE_N == WRITE_ON);
  assign cmd.load = (BURST_STEP_OR_LOAD == LOAD_LEVEL);
  assign cmd.addr = ADDR;
  for (genvar i = 0; i < LANES; i++) begin : g_mask
    assign cmd.lane_en[i] = (BYTE_WRITE_MASK_N[i] == MASK_ON);
  end

  // ----------------------------------------
  // access and burst state
  // ----------------------------------------
  fts_op_type op_q; // access in progress
  fts_op_type op_d;
  logic [BASE_W-1:0] base_q; // aligned group address
  logic [BASE_W-1:0] base_d;
  logic [BURST_W-1:0] start_q; // seed low bits
  logic [BURST_W-1:0] start_d;
  logic [BURST_W-1:0] cnt_q; // words stepped so far
  logic [BURST_W-1:0] cnt_d;
  logic [LANES-1:0] lanes_q; // lanes for data phase
  logic [LANES-1:0] lanes_d;
  logic desel_q; // previous qualified edge deselected
  logic desel_d;
  logic [BURST_W-1:0] low_now; // low bits this edge
  logic [ADDR_W-1:0] addr_now; // word addressed this edge

  // next access state
  always_comb begin
    op_d = op_q;
    base_d = base_q;
    start_d = start_q;
    cnt_d = cnt_q;
    lanes_d = lanes_q;
    desel_d = desel_q;
    low_now = BURST_ZERO;
    if (cmd.gate) begin
      if (cmd.load) begin
        if (cmd.selected) begin
          op_d = cmd.write ? OP_WRITE : OP_READ;
        end else begin
          op_d = OP_IDLE;
        end
        base_d = cmd.addr[ADDR_W-1:BURST_W];
        start_d = cmd.addr[BURST_W-1:0];
        cnt_d = BURST_ZERO;
        low_now = cmd.addr[BURST_W-1:0];
      end else begin
        cnt_d = cnt_q + BURST_STEP;
        if (interleave_q) begin
          low_now = start_q ^ cnt_d;
        end else begin
          low_now = start_q + cnt_d;
        end
      end
      lanes_d = cmd.lane_en;
      desel_d = (op_d == OP_IDLE);
    end
    // gate high leaves every field held
  end

  assign addr_now = {base_d, low_now};

  // access state register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= OP_IDLE;
      base_q <= BASE_ZERO;
      start_q <= BURST_ZERO;
      cnt_q <= BURST_ZERO;
      lanes_q <= LANES_OFF;
      desel_q <= 1'b1;
    end else begin
      op_q <= op_d;
      base_q <= base_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      lanes_q <= lanes_d;
      desel_q <= desel_d;
    end
  end

  // ----------------------------------------
  // write data phase
  // ----------------------------------------
  logic wr_pend_q; // data expected at next edge
  logic wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q; // target of pending data
  logic [ADDR_W-1:0] wr_addr_d;
  fts_wr_type wr; // array write this edge
  logic rd_en; // array read this edge

  // next pending write
  always_comb begin
    wr_pend_d = wr_pend_q;
    wr_addr_d = wr_addr_q;
    if (cmd.gate) begin
      wr_pend_d = (op_d == OP_WRITE);
      wr_addr_d = addr_now;
    end
  end

  // pending write register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= ADDR_ZERO;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // data pins written on the edge
  assign wr.en = cmd.gate && wr_pend_q;
  assign wr.addr = wr_addr_q;
  // only enabled lanes reach the array
  assign wr.lane_en = lanes_q;
  assign wr.data = DQ_I;

  // read word addressed at this edge
  assign rd_en = cmd.gate && (op_d == OP_READ);

  // ----------------------------------------
  // data pin direction
  // ----------------------------------------
  logic drive_q; // read data owns the bus
  logic drive_d;
  logic dq_oe_q; // pin enable register
  logic dq_oe_d;

  // next direction
  always_comb begin
    drive_d = drive_q;
    if (cmd.gate) begin
      // no drive on write, desel or first after
      drive_d = (op_d == OP_READ) && !desel_q;
    end
    dq_oe_d = drive_d && (oe_s2_q == OE_ON);
  end

  // direction register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      drive_q <= 1'b0;
      dq_oe_q <= 1'b0;
    end else begin
      drive_q <= drive_d;
      dq_oe_q <= dq_oe_d;
    end
  end

  // ----------------------------------------
  // ready pin
  // ----------------------------------------
  fts_rdy_type rdy_q; // ready sequence state
  fts_rdy_type rdy_d;
  logic [INIT_CNT_W-1:0] init_q; // init cycles spent
  logic [INIT_CNT_W-1:0] init_d;
  logic ready_o_q; // ready level
  logic ready_o_d;
  logic ready_oe_q; // ready driven
  logic ready_oe_d;

  // low while initialising, one high cycle
  always_comb begin
    rdy_d = rdy_q;
    init_d = init_q;
    ready_o_d = 1'b0;
    ready_oe_d = 1'b0;
    unique case (rdy_q)
      RDY_INIT: begin
        ready_oe_d = 1'b1;
        init_d = init_q + INIT_ONE;
        if (init_d >= INIT_CYCLES) begin
          rdy_d = RDY_PULSE;
          ready_o_d = 1'b1;
        end
      end
      RDY_PULSE: begin
        rdy_d = RDY_DONE;
      end
      RDY_DONE: begin
        rdy_d = RDY_DONE;
      end
    endcase
  end

  // ready register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdy_q <= RDY_INIT;
      init_q <= INIT_ZERO;
      ready_o_q <= 1'b0;
      ready_oe_q <= 1'b1;
    end else begin
      rdy_q <= rdy_d;
      init_q <= init_d;
      ready_o_q <= ready_o_d;
      ready_oe_q <= ready_oe_d;
    end
  end

  // ----------------------------------------
  // array and outputs
  // ----------------------------------------
  // word store with registered read
  fts_mem u_mem (
    .clk(CLK),
    .rst_n(rst_n),
    .rd_en(rd_en),
    .rd_addr(addr_now),
    .wr(wr),
    .rd_data(DQ_O)
  );

  assign DQ_OE = dq_oe_q;
  assign READY_O = ready_o_q;
  assign READY_OE = ready_oe_q;

endmodule
`default_nettype wire

// >>> tb/fts_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fts_chk
  import fts_pkg::*;
#(
  parameter logic [INIT_CNT_W-1:0] INIT_CYCLES = 16'h0010
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SELECT_LOW_A_N,
  input wire logic SELECT_HIGH_B,
  input wire logic SELECT_LOW_C_N,
  input wire logic WE_N,
  input wire logic BURST_STEP_OR_LOAD,
  input wire logic CLOCK_GATE_N,
  input wire logic OE_N,
  input wire logic [DATA_W-1:0] DQ_O,
  input wire logic DQ_OE,
  input wire logic READY_O,
  input wire logic READY_OE
);
  // ------
  // helper state
  // ------
  logic qual; // edge not gated
  logic sel; // selects in the on pattern
  logic ld; // load edge
  logic act_q; // last qualified edge was an access
  logic act_d;
  localparam int READY_LAT = INIT_CYCLES + 2; // edges from release to the ready pulse
  assign qual = CLOCK_GATE_N == GATE_ON;
  assign sel = {SELECT_LOW_A_N, SELECT_HIGH_B, SELECT_LOW_C_N} == {SEL_A_ON, SEL_B_ON, SEL_C_ON};
  assign ld = BURST_STEP_OR_LOAD == LOAD_LEVEL;
  // advances keep the kind of the last load
  always_comb begin
    act_d = act_q;
    if (qual && ld) begin
      act_d = sel;
    end
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      act_q <= 1'b0;
    end else begin
      act_q <= act_d;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  // ------
  // properties
  // ------
  property p_gate_hold;
    CLOCK_GATE_N |=> $stable(DQ_O);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("read data moved on a gated edge");
  property p_wr_hiz;
    qual && sel && ld && WE_N == WRITE_ON |=> !DQ_OE;
  endproperty
  a_wr_hiz: assert property (p_wr_hiz)
    else $error("pins driven in a write data phase");
  property p_desel_hiz;
    qual && ld && !sel |=> !DQ_OE;
  endproperty
  a_desel_hiz: assert property (p_desel_hiz)
    else $error("pins driven while deselected");
  property p_emerge_hiz;
    qual && !act_q |=> !DQ_OE;
  endproperty
  a_emerge_hiz: assert property (p_emerge_hiz)
    else $error("pins driven on the first edge after idle");
  property p_oe_off;
    OE_N [*4] |=> !DQ_OE;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("pins driven with output enable off");
  property p_oe_read;
    !OE_N [*4] ##0 (qual && act_q && sel && ld && WE_N != WRITE_ON) |=> DQ_OE;
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("read data not driven");
  property p_ready_pulse;
    READY_O && READY_OE |=> !READY_OE [*8];
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready not released after its pulse");
  property p_ready_init;
    $rose(ARST_N) |-> READY_OE && !READY_O;
  endproperty
  a_ready_init: assert property (p_ready_init)
    else $error("ready not low after reset");
  property p_ready_time;
    $rose(ARST_N) |-> ##READY_LAT (READY_O && READY_OE);
  endproperty
  a_ready_time: assert property (p_ready_time)
    else $error("ready pulse not at the end of init");
endmodule
bind fts_port fts_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .CLK(CLK), .ARST_N(ARST_N), .SELECT_LOW_A_N(SELECT_LOW_A_N),
  .SELECT_HIGH_B(SELECT_HIGH_B), .SELECT_LOW_C_N(SELECT_LOW_C_N), .WE_N(WE_N),
  .BURST_STEP_OR_LOAD(BURST_STEP_OR_LOAD), .CLOCK_GATE_N(CLOCK_GATE_N), .OE_N(OE_N),
  .DQ_O(DQ_O), .DQ_OE(DQ_OE), .READY_O(READY_O), .READY_OE(READY_OE));
`default_nettype wire

// >>> tb/fts_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module fts_ctl
  import fts_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] addr,
  output logic [2:0] sel_pins,
  output logic we_n,
  output logic [LANES-1:0] mask_n,
  output logic step,
  output logic gate_n,
  output logic [DATA_W-1:0] dq
);
  logic pend_w; // write data owed at next edge
  logic [DATA_W-1:0] pend_d; // that data
  logic kind_w; // last load was a write
  // quiet, gated bus at start
  initial begin
    addr <= ADDR_ZERO;
    sel_pins <= 3'h7;
    we_n <= ~WRITE_ON;
    mask_n <= 6'h3f;
    step <= LOAD_LEVEL;
    gate_n <= ~GATE_ON;
    dq <= DATA_ZERO;
    pend_w <= 1'b0;
    pend_d <= DATA_ZERO;
    kind_w = 1'b0;
  end
  // one command per qualified edge
  task automatic op(input logic stp, input logic [2:0] sel, input logic wr,
                    input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m,
                    input logic [DATA_W-1:0] d);
    @(posedge clk);
    if (stp == LOAD_LEVEL) begin
      kind_w = wr && (sel == {SEL_A_ON, SEL_B_ON, SEL_C_ON});
    end
    // address and selects count on loads
    addr <= (stp == LOAD_LEVEL) ? a : ~addr;
    sel_pins <= sel;
    // write low with its lane enables
    we_n <= wr ? WRITE_ON : ~WRITE_ON;
    mask_n <= m;
    step <= stp;
    gate_n <= GATE_ON;
    // data only in its data phase, else a moving pattern
    dq <= pend_w ? pend_d : ~dq;
    pend_w <= kind_w;
    pend_d <= d;
    #1;
  endtask
  // slow controller: gate edges with a bogus write held
  task automatic stall(input int n);
    @(posedge clk);
    gate_n <= ~GATE_ON;
    we_n <= WRITE_ON;
    addr <= ~addr;
    repeat (n) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fts_pkg::*;
  localparam logic [2:0] ON = {SEL_A_ON, SEL_B_ON, SEL_C_ON}; // selected pattern
  localparam logic [ADDR_W-1:0] WA = 21'h00100; // lane test word
  localparam logic [ADDR_W-1:0] WB = 21'h00200; // stall test word
  localparam logic [DATA_W-1:0] DB = 48'h5a5a5a5a5a5a; // stall test data
  logic CLK;
  logic ARST_N;
  logic OE_N;
  logic BURST_ORDER;
  logic [ADDR_W-1:0] addr;
  logic [2:0] sel_pins;
  logic we_n;
  logic [LANES-1:0] mask_n;
  logic step;
  logic gate_n;
  logic [DATA_W-1:0] ctl_dq;
  logic [DATA_W-1:0] DQ_O;
  logic DQ_OE;
  logic READY_O;
  logic READY_OE;
  logic [DATA_W-1:0] dq_bus; // resolved data pins
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]]; // expected memory
  int err_count;
  int compares;
  assign dq_bus = DQ_OE ? DQ_O : ctl_dq;
  fts_ctl ctl (.clk(CLK), .addr(addr), .sel_pins(sel_pins), .we_n(we_n), .mask_n(mask_n),
    .step(step), .gate_n(gate_n), .dq(ctl_dq));
  fts_port #(.INIT_CYCLES(16'h0002)) dut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(addr),
    .SELECT_LOW_A_N(sel_pins[2]), .SELECT_HIGH_B(sel_pins[1]), .SELECT_LOW_C_N(sel_pins[0]),
    .WE_N(we_n), .BYTE_WRITE_MASK_N(mask_n), .BURST_STEP_OR_LOAD(step),
    .CLOCK_GATE_N(gate_n), .OE_N(OE_N), .BURST_ORDER(BURST_ORDER), .DQ_I(dq_bus),
    .DQ_O(DQ_O), .DQ_OE(DQ_OE), .READY_O(READY_O), .READY_OE(READY_OE));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // ------
  // helpers
  // ------
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic oe, input logic [DATA_W-1:0] d);
    check(DATA_W'(DQ_OE), DATA_W'(oe));
    check(DQ_O, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    ctl.op(1'b0, ON, 1'b0, a, 6'h3f, DATA_ZERO);
  endtask
  function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] s, input int n,
                                              input logic o);
    return {s[ADDR_W-1:2], o ? s[1:0] ^ 2'(n) : s[1:0] + 2'(n)};
  endfunction
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  task automatic do_reset(input logic o);
    int n;
    ctl.op(1'b0, 3'h7, 1'b0, ADDR_ZERO, 6'h3f, DATA_ZERO);
    @(posedge CLK);
    ARST_N <= 1'b0;
    BURST_ORDER <= o;
    repeat (20) @(posedge CLK);
    check(DQ_O, DATA_ZERO);
    check(DATA_W'({READY_OE, READY_O, DQ_OE}), 48'h4);
    ARST_N <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK);
      #1;
      if (READY_O === 1'b1 && READY_OE === 1'b1) begin
        break;
      end
    end
    if (n == 100) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic t_lanes();
    ctl.op(1'b0, ON, 1'b1, WA, 6'h00, 48'h0123456789ab);
    ctl.op(1'b0, ON, 1'b1, WA, 6'h2a, 48'hffeeddccbbaa);
    check(DATA_W'(DQ_OE), DATA_ZERO);
    rd(WA);
    rd(WA);
    chk_rd(1'b1, 48'h01ee45cc89aa);
    shadow[WA] = 48'h01ee45cc89aa;
  endtask
  task automatic t_burst(input logic o);
    logic [DATA_W-1:0] d;
    for (int n = 0; n < 4; n++) begin
      d = {40'h0a1b2c3d4e, o, 7'(n)};
      ctl.op(n != 0, ON, 1'b1, 21'h1abc6, 6'h00, d);
      shadow[baddr(21'h1abc6, n, o)] = d;
    end
    rd(21'h1abc5);
    for (int n = 0; n < 6; n++) begin
      ctl.op(1'b1, ON, 1'b0, ADDR_ZERO, 6'h3f, DATA_ZERO);
      chk_rd(1'b1, shadow[baddr(21'h1abc5, n, o)]);
    end
  endtask
  task automatic t_desel();
    for (int c = 0; c < 8; c++) begin
      if (3'(c) != ON) begin
        ctl.op(1'b0, 3'(c), 1'b1, WA, 6'h00, DATA_ZERO);
        rd(WA);
        rd(WA);
        chk_rd(1'b0, shadow[WA]);
        rd(WA);
        chk_rd(1'b1, shadow[WA]);
      end
    end
    ctl.op(1'b0, 3'h7, 1'b0, WA, 6'h3f, DATA_ZERO);
    ctl.op(1'b1, ON, 1'b0, ADDR_ZERO, 6'h3f, DATA_ZERO);
    ctl.op(1'b1, ON, 1'b0, ADDR_ZERO, 6'h3f, DATA_ZERO);
    check(DATA_W'(DQ_OE), DATA_ZERO);
  endtask
  task automatic t_stall();
    ctl.op(1'b0, ON, 1'b1, WB, 6'h00, DB);
    ctl.stall(3);
    rd(WB);
    rd(WA);
    chk_rd(1'b1, DB);
    ctl.stall(4);
    chk_rd(1'b1, shadow[WA]);
    rd(WB);
    rd(WB);
    chk_rd(1'b1, DB);
  endtask
  task automatic t_oe();
    @(posedge CLK);
    OE_N <= 1'b1;
    repeat (4) rd(WA);
    chk_rd(1'b0, shadow[WA]);
    @(posedge CLK);
    OE_N <= 1'b0;
    repeat (4) rd(WA);
    chk_rd(1'b1, shadow[WA]);
  endtask
  initial begin
    err_count = 0;
    compares = 0;
    ARST_N <= 1'b0;
    OE_N <= 1'b0;
    BURST_ORDER <= 1'b0;
    do_reset(1'b0);
    t_lanes();
    t_burst(1'b0);
    t_desel();
    t_stall();
    t_oe();
    do_reset(1'b1);
    t_burst(1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
